// [pkg/chp_port_map.svh]
/*
  Constants of the configuration and host bus port: cycle counts, field
  positions, transfer-size codes and reset values.
  Assumes it is included by bare name wherever one of these is needed.
*/
`ifndef CHP_PORT_MAP_SVH
`define CHP_PORT_MAP_SVH

// ****************************************************************
// timing counts at the 50 MHz block clock
// ****************************************************************
`define CHP_POWER_CYCLES   16'h0040
`define CHP_CLEAR_CYCLES   16'h0100
`define CHP_CONFIG_BYTES   16'h0010
`define CHP_BUSY_CYCLES    4'h4
`define CHP_MP_PULSE       4'h4

// ****************************************************************
// field positions and codes
// ****************************************************************
`define CHP_STATUS_READY   7
`define CHP_STATUS_LOW     3
`define CHP_IDX_HI         3
`define CHP_IDX_LO         2
`define CHP_LANE_HI        1
`define CHP_LANE_LO        0
`define CHP_SIZE_WORD      2'h0
`define CHP_SIZE_BYTE      2'h1
`define CHP_SIZE_HALF      2'h2
`define CHP_BEAT_STEP      18'h0_0004
`define CHP_CFG_ADDR_RESET 22'h00_0000
`define CHP_WORDS          4

`endif

// [pkg/chp_pkg.sv]
/*
  Types of the configuration and host bus port: state and mode
  enumerations, the sampled pin bundle and the host request record.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package chp_pkg;

  // ****************************************************************
  // configuration sequence, one-hot
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_POWER = 5'h01,
    ST_CLEAR = 5'h02,
    ST_WAIT  = 5'h04,
    ST_LOAD  = 5'h08,
    ST_DONE  = 5'h10
  } chp_cfg_state_t;

  // configuration modes as strapped
  typedef enum logic [1:0] {
    MODE_PERIPH = 2'h0,
    MODE_MASTER = 2'h1,
    MODE_SLAVE  = 2'h2,
    MODE_PROC   = 2'h3
  } chp_mode_t;

  // host port sequence, one-hot
  typedef enum logic [1:0] {
    HS_IDLE = 2'h1,
    HS_BEAT = 2'h2
  } chp_host_state_t;

  // every pin input, after the synchroniser
  typedef struct packed {
    logic        scan_used;
    chp_mode_t   mode;
    logic        init_n;
    logic        cs0_n;
    logic        cs1;
    logic        strobe_n;
    logic        write_dir;
    logic        hclk;
    logic        burst_n;
    logic        burst_cont;
    logic [1:0]  tsize;
    logic [17:0] addr;
    logic [31:0] data;
  } chp_pins_t;

  // one host beat as captured
  typedef struct packed {
    logic        dir;
    logic        burst_n;
    logic [1:0]  size;
    logic [17:0] addr;
  } chp_req_t;

endpackage : chp_pkg

// [hdl/chp_sync.sv]
/*
  Two-stage synchroniser for a bundle of pin inputs.
  Assumes the bundle is quasi-static or sampled with enough margin by the
  reader; multi-bit words are not made coherent here.
*/
`timescale 1ns/1ns

module chp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             CLOCK,
  input  wire logic             NRST,
  // bundle
  input  wire logic [WIDTH-1:0] D,
  output logic      [WIDTH-1:0] Q
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      meta <= '0;
      Q    <= '0;
    end else begin
      meta <= D;
      Q    <= meta;
    end
  end

endmodule : chp_sync

// [hdl/chp_port.sv]
/*
  Configuration port and host processor bus slave port sharing pins.
  Assumes all pin inputs and the host bus clock are asynchronous to CLOCK
  and that the host clock is well below a quarter of CLOCK.
*/
`timescale 1ns/1ns
`include "chp_port_map.svh"

module chp_port (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  // straps and scan
  input  wire logic [1:0]  MODE,
  input  wire logic        SCAN_USED,
  output logic             SCAN_ENABLE,
  // configuration progress
  output logic             CONFIG_PENDING_HIGH,
  output logic             CONFIG_PENDING_LOW_N,
  // open-drain init line
  input  wire logic        INIT_IN,
  output logic             INIT_OUT,
  output logic             INIT_OE_N,
  // selects and strobes
  input  wire logic        SELECT_ACTIVE_LOW_N,
  input  wire logic        SELECT_ACTIVE_HIGH,
  input  wire logic        HOST_TRANSFER_STROBE_N,
  input  wire logic        HOST_DIRECTION,
  output logic             READY_PULSE,
  // shared data bus
  input  wire logic [31:0] DATA_IN,
  output logic      [31:0] DATA_OUT,
  output logic      [31:0] DATA_OE_N,
  // configuration memory address
  output logic      [21:0] CFG_ADDR,
  // host processor port
  input  wire logic        HOST_BUS_CLOCK,
  input  wire logic [17:0] HOST_ADDRESS_LOW,
  input  wire logic        HOST_BURST_N,
  input  wire logic        HOST_BURST_CONTINUE,
  input  wire logic [1:0]  HOST_TRANSFER_SIZE,
  output logic             HOST_ACKNOWLEDGE_N,
  // configuration bytes toward the array
  output logic      [7:0]  CFG_BYTE,
  output logic             CFG_BYTE_VALID
);

  // ****************************************************************
  // sampling of pins
  // ****************************************************************
  chp_pkg::chp_pins_t       pins;
  chp_pkg::chp_pins_t       raw;
  chp_pkg::chp_cfg_state_t  state;
  chp_pkg::chp_mode_t       mode;
  chp_pkg::chp_host_state_t hstate;
  chp_pkg::chp_req_t        req;
  logic [15:0] cnt;
  logic [15:0] byte_cnt;
  logic [3:0]  busy_cnt;
  logic [3:0]  mp_cnt;
  logic [31:0] mem [`CHP_WORDS];
  logic        wr_q;
  logic        hclk_q;
  logic        host_reading;
  logic        sel;
  logic        ready_int;
  logic        take_pw;
  logic        take_mp;
  logic        take_proc;
  logic        cfg_take;
  logic        status_rd;
  logic        hclk_rise;
  logic        host_on;
  logic        beat_go;
  logic        beat_cont;
  chp_pkg::chp_req_t beat;
  logic [3:0]  lanes;

  assign raw = '{scan_used: SCAN_USED, mode: chp_pkg::chp_mode_t'(MODE), init_n: INIT_IN,
                 cs0_n: SELECT_ACTIVE_LOW_N, cs1: SELECT_ACTIVE_HIGH,
                 strobe_n: HOST_TRANSFER_STROBE_N, write_dir: HOST_DIRECTION,
                 hclk: HOST_BUS_CLOCK, burst_n: HOST_BURST_N,
                 burst_cont: HOST_BURST_CONTINUE, tsize: HOST_TRANSFER_SIZE,
                 addr: HOST_ADDRESS_LOW, data: DATA_IN};

  chp_sync #(.WIDTH($bits(chp_pkg::chp_pins_t))) u_sync (
    .CLOCK (CLOCK),
    .NRST  (NRST),
    .D     (raw),
    .Q     (pins)
  );

  // byte lanes of a host access; lane 0 is the least significant byte, taken by byte address 3
  function automatic logic [3:0] lane_mask(input logic [1:0] size, input logic [1:0] a);
    logic [3:0] m;
    m = 4'hF;
    case (size)
      `CHP_SIZE_BYTE: m = 4'h8 >> a;
      `CHP_SIZE_HALF: m = a[1] ? 4'h3 : 4'hC;
      default:        m = 4'hF;
    endcase
    return m;
  endfunction : lane_mask

  // edge history of the write strobe and the host clock
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      wr_q   <= 1'b1;
      hclk_q <= 1'b0;
    end else begin
      wr_q   <= pins.write_dir;
      hclk_q <= pins.hclk;
    end
  end

  // ****************************************************************
  // configuration sequence
  // ****************************************************************
  assign sel       = !pins.cs0_n && pins.cs1;
  assign ready_int = (busy_cnt == 4'h0);
  assign take_pw   = (state == chp_pkg::ST_LOAD) && sel && ready_int &&
                     (mode == chp_pkg::MODE_PERIPH || mode == chp_pkg::MODE_SLAVE) &&
                     wr_q && !pins.write_dir;
  assign take_mp   = (state == chp_pkg::ST_LOAD) && (mode == chp_pkg::MODE_MASTER) &&
                     (mp_cnt == `CHP_MP_PULSE);
  assign cfg_take  = take_pw || take_mp || take_proc;

  // power, clear, wait for init release, load, done
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      state    <= chp_pkg::ST_POWER;
      cnt      <= 16'h0000;
      byte_cnt <= 16'h0000;
      mode     <= chp_pkg::MODE_PERIPH;
    end else begin
      case (state)
        chp_pkg::ST_POWER: begin
          cnt <= cnt + 16'h0001;
          if (cnt == `CHP_POWER_CYCLES - 16'h0001) begin
            cnt   <= 16'h0000;
            state <= chp_pkg::ST_CLEAR;
          end
        end
        chp_pkg::ST_CLEAR: begin
          cnt <= cnt + 16'h0001;
          if (cnt == `CHP_CLEAR_CYCLES - 16'h0001) begin
            state <= chp_pkg::ST_WAIT;
          end
        end
        chp_pkg::ST_WAIT: begin
          // an outside party keeps init low to delay the start
          if (pins.init_n) begin
            mode  <= pins.mode;
            state <= chp_pkg::ST_LOAD;
          end
        end
        chp_pkg::ST_LOAD: begin
          if (cfg_take) begin
            byte_cnt <= byte_cnt + 16'h0001;
            if (byte_cnt == `CHP_CONFIG_BYTES - 16'h0001) begin
              state <= chp_pkg::ST_DONE;
            end
          end
        end
        chp_pkg::ST_DONE: state <= chp_pkg::ST_DONE;
        default:          state <= chp_pkg::ST_POWER;
      endcase
    end
  end

  // progress pins and open-drain init; init is only ever pulled low
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      CONFIG_PENDING_HIGH  <= 1'b1;
      CONFIG_PENDING_LOW_N <= 1'b0;
      INIT_OUT             <= 1'b0;
      INIT_OE_N            <= 1'b0;
      SCAN_ENABLE          <= 1'b1;
    end else begin
      CONFIG_PENDING_HIGH  <= (state != chp_pkg::ST_DONE);
      CONFIG_PENDING_LOW_N <= (state == chp_pkg::ST_DONE);
      INIT_OUT             <= 1'b0;
      INIT_OE_N            <= !(state == chp_pkg::ST_POWER ||
                                state == chp_pkg::ST_CLEAR);
      SCAN_ENABLE          <= !(state == chp_pkg::ST_DONE && !pins.scan_used);
    end
  end

  // busy time after a peripheral byte, read pulse timing in master mode
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      busy_cnt <= 4'h0;
      mp_cnt   <= 4'h0;
    end else begin
      if (take_pw) begin
        busy_cnt <= `CHP_BUSY_CYCLES;
      end else if (busy_cnt != 4'h0) begin
        busy_cnt <= busy_cnt - 4'h1;
      end
      if (state == chp_pkg::ST_LOAD && mode == chp_pkg::MODE_MASTER) begin
        mp_cnt <= take_mp ? 4'h0 : mp_cnt + 4'h1;
      end else begin
        mp_cnt <= 4'h0;
      end
    end
  end

  // shared ready pin: byte ready, master read pulse, or plain status
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      READY_PULSE <= 1'b0;
    end else if (state == chp_pkg::ST_LOAD && mode == chp_pkg::MODE_MASTER) begin
      READY_PULSE <= (mp_cnt < `CHP_MP_PULSE);
    end else if (state == chp_pkg::ST_LOAD && mode == chp_pkg::MODE_PERIPH) begin
      READY_PULSE <= ready_int && !take_pw;
    end else begin
      READY_PULSE <= (state == chp_pkg::ST_LOAD);
    end
  end

  // taken bytes and the memory address in master parallel mode
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      CFG_BYTE       <= 8'h00;
      CFG_BYTE_VALID <= 1'b0;
      CFG_ADDR       <= `CHP_CFG_ADDR_RESET;
    end else begin
      CFG_BYTE_VALID <= cfg_take;
      if (take_proc) begin
        CFG_BYTE <= pins.data[7:0];
      end else if (cfg_take) begin
        CFG_BYTE <= pins.data[7:0];
      end
      if (take_mp) begin
        CFG_ADDR <= CFG_ADDR + 22'h00_0001;
      end
    end
  end

  // ****************************************************************
  // host processor port
  // ****************************************************************
  // the host clock is sampled; its rising edges pace every beat
  assign hclk_rise = pins.hclk && !hclk_q;
  assign host_on   = sel && (state == chp_pkg::ST_DONE ||
                     (state == chp_pkg::ST_LOAD && mode == chp_pkg::MODE_PROC));
  assign beat_cont = (hstate == chp_pkg::HS_BEAT) && !req.burst_n &&
                     pins.burst_cont;
  assign beat_go   = hclk_rise && (beat_cont || (hstate == chp_pkg::HS_IDLE &&
                     host_on && !pins.strobe_n));
  assign take_proc = beat_go && !beat.dir && (state == chp_pkg::ST_LOAD);

  // next beat: a fresh request, or the current one stepped one word
  always_comb begin
    beat = req;
    if (hstate == chp_pkg::HS_IDLE) begin
      beat = '{dir: pins.write_dir, burst_n: pins.burst_n,
               size: pins.tsize, addr: pins.addr};
    end else begin
      beat.addr = req.addr + `CHP_BEAT_STEP;
    end
  end

  // acknowledge stays low for one host clock per beat
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      hstate             <= chp_pkg::HS_IDLE;
      req                <= '0;
      HOST_ACKNOWLEDGE_N <= 1'b1;
    end else if (hclk_rise) begin
      case (hstate)
        chp_pkg::HS_IDLE: begin
          if (beat_go) begin
            req                <= beat;
            hstate             <= chp_pkg::HS_BEAT;
            HOST_ACKNOWLEDGE_N <= 1'b0;
          end
        end
        chp_pkg::HS_BEAT: begin
          if (beat_cont) begin
            req <= beat;
          end else begin
            hstate             <= chp_pkg::HS_IDLE;
            HOST_ACKNOWLEDGE_N <= 1'b1;
          end
        end
        default: hstate <= chp_pkg::HS_IDLE;
      endcase
    end
  end

  // lanes of the beat being taken; a select on a call result is not portable
  assign lanes = lane_mask(beat.size, beat.addr[`CHP_LANE_HI:`CHP_LANE_LO]);

  // user word store, written lane by lane from the size field
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      for (int i = 0; i < `CHP_WORDS; i++) begin
        mem[i] <= 32'h0000_0000;
      end
    end else if (beat_go && !beat.dir && state == chp_pkg::ST_DONE) begin
      for (int l = 0; l < 4; l++) begin
        if (lanes[l]) begin
          mem[beat.addr[`CHP_IDX_HI:`CHP_IDX_LO]][8*l +: 8] <= pins.data[8*l +: 8];
        end
      end
    end
  end

  // ****************************************************************
  // shared data bus
  // ****************************************************************
  // write strobe low suppresses the status read
  assign status_rd = (mode == chp_pkg::MODE_PERIPH) && (state != chp_pkg::ST_DONE) &&
                     sel && !pins.strobe_n && pins.write_dir;

  // the bus is released unless a selected read owns it
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      DATA_OUT     <= 32'h0000_0000;
      DATA_OE_N    <= 32'hFFFF_FFFF;
      host_reading <= 1'b0;
    end else begin
      if (beat_go) begin
        host_reading <= beat.dir;
      end else if (!sel || (hclk_rise && hstate == chp_pkg::HS_BEAT)) begin
        host_reading <= 1'b0;
      end
      if (status_rd) begin
        DATA_OUT  <= {24'h00_0000, ready_int, state[3:0], 3'h0};
        DATA_OE_N <= 32'hFFFF_FF07;
      end else if (host_reading && sel) begin
        DATA_OUT  <= mem[req.addr[`CHP_IDX_HI:`CHP_IDX_LO]];
        DATA_OE_N <= 32'h0000_0000;
      end else begin
        DATA_OE_N <= 32'hFFFF_FFFF;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  property p_pend_high;
    ##1 CONFIG_PENDING_HIGH == ($past(state) != chp_pkg::ST_DONE);
  endproperty
  a_pend_high: assert property (p_pend_high) else $error("high pending wrong");

  property p_pend_pair;
    CONFIG_PENDING_LOW_N == !CONFIG_PENDING_HIGH;
  endproperty
  a_pend_pair: assert property (p_pend_pair) else $error("pending pins disagree");

  property p_init_low;
    (state == chp_pkg::ST_CLEAR) |=> !INIT_OE_N && !INIT_OUT;
  endproperty
  a_init_low: assert property (p_init_low) else $error("init not held low");

  property p_wait_hold;
    (state == chp_pkg::ST_WAIT && !pins.init_n) |=> (state == chp_pkg::ST_WAIT);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("left wait with init low");

  property p_sel_take;
    take_pw |-> $past(!SELECT_ACTIVE_LOW_N && SELECT_ACTIVE_HIGH, 2);
  endproperty
  a_sel_take: assert property (p_sel_take) else $error("byte taken unselected");

  property p_busy;
    (take_pw && mode == chp_pkg::MODE_PERIPH) |=> !READY_PULSE ##1 !READY_PULSE;
  endproperty
  a_busy: assert property (p_busy) else $error("ready not dropped");

  property p_status;
    status_rd |=> !DATA_OE_N[`CHP_STATUS_READY] &&
                  DATA_OUT[`CHP_STATUS_READY] == $past(ready_int);
  endproperty
  a_status: assert property (p_status) else $error("status not on bus");

  property p_wr_prio;
    (mode == chp_pkg::MODE_PERIPH && state != chp_pkg::ST_DONE && !pins.write_dir)
      |=> &DATA_OE_N;
  endproperty
  a_wr_prio: assert property (p_wr_prio) else $error("bus driven during write");

  property p_rclk;
    ($fell(READY_PULSE) && state == chp_pkg::ST_LOAD && mode == chp_pkg::MODE_MASTER)
      |-> $past(READY_PULSE, `CHP_MP_PULSE);
  endproperty
  a_rclk: assert property (p_rclk) else $error("read pulse too short");

  property p_addr_step;
    take_mp |=> CFG_ADDR == $past(CFG_ADDR) + 22'h00_0001;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address not stepped");

  property p_ack;
    (beat_go && hstate == chp_pkg::HS_IDLE) |=> !HOST_ACKNOWLEDGE_N;
  endproperty
  a_ack: assert property (p_ack) else $error("no acknowledge");

  property p_scan;
    (state == chp_pkg::ST_DONE && !pins.scan_used) |=> !SCAN_ENABLE;
  endproperty
  a_scan: assert property (p_scan) else $error("scan left enabled");

  property p_bus_owner;
    !(&DATA_OE_N) |-> $past(status_rd) || $past(host_reading && sel);
  endproperty
  a_bus_owner: assert property (p_bus_owner) else $error("bus driven unowned");

  c_done:  cover property (state == chp_pkg::ST_LOAD ##1 state == chp_pkg::ST_DONE);
  c_burst: cover property (beat_go && beat_cont);
  c_stat:  cover property (status_rd ##1 !DATA_OE_N[`CHP_STATUS_READY]);
  c_mp:    cover property (take_mp);

endmodule : chp_port

// [verif/chp_far_model.sv]
/*
  Far side of the port: init wire with pull-up and an external holder,
  and a configuration memory answering the byte address.
  Assumes the port never drives init high; it only releases it.
*/
`timescale 1ns/1ns

module chp_far_model (
  // init line
  input  wire logic        HOLD,
  input  wire logic        INIT_OE_N,
  output logic             INIT_LEVEL,
  // configuration memory
  input  wire logic [21:0] ADDR,
  output logic      [7:0]  MEM_BYTE
);
  // pull-up wins unless either party pulls low
  assign INIT_LEVEL = ~HOLD & INIT_OE_N;
  // content follows address, so a wrong address shows as a wrong byte
  assign MEM_BYTE = ADDR[7:0] + 8'h30;
endmodule : chp_far_model

// [verif/chp_port_tb.sv]
/*
  Self-checking bench of the configuration and host bus port.
  Assumes the far model drives init and memory data; bench drives the rest.
*/
`timescale 1ns/1ns

module chp_port_tb;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        clock = 1'h0, nrst = 1'h0, hold = 1'h1, sel_n = 1'h1, sel = 1'h0;
  logic        rd_n = 1'h1, wr = 1'h1, hclk = 1'h0, bn = 1'h1, bc = 1'h0;
  logic        init_out;
  logic [1:0]  mode = 2'h0, tsize = 2'h0;
  logic [17:0] haddr = 18'h0_0000;
  logic [31:0] din = 32'h0000_0000, dout, doe_n, data_in;
  logic [21:0] cfg_addr;
  logic [7:0]  cfg_byte, mem_byte;
  logic        scan_en, pend_hi, pend_lo_n, init_oe_n, init_lvl, rdy, ack_n, cfg_valid;
  int          errors = 0, n_tests = 0;

  always #10 clock = ~clock;
  // memory owns the low byte only while the port masters it
  assign data_in = (mode == 2'h1) ? {24'h00_0000, mem_byte} : din;

  chp_far_model far (.HOLD(hold), .INIT_OE_N(init_oe_n), .INIT_LEVEL(init_lvl),
    .ADDR(cfg_addr), .MEM_BYTE(mem_byte));
  chp_port uut (.CLOCK(clock), .NRST(nrst), .MODE(mode), .SCAN_USED(1'h0),
    .SCAN_ENABLE(scan_en), .CONFIG_PENDING_HIGH(pend_hi), .CONFIG_PENDING_LOW_N(pend_lo_n),
    .INIT_IN(init_lvl), .INIT_OUT(init_out), .INIT_OE_N(init_oe_n), .SELECT_ACTIVE_LOW_N(sel_n),
    .SELECT_ACTIVE_HIGH(sel), .HOST_TRANSFER_STROBE_N(rd_n), .HOST_DIRECTION(wr),
    .READY_PULSE(rdy), .DATA_IN(data_in), .DATA_OUT(dout), .DATA_OE_N(doe_n),
    .CFG_ADDR(cfg_addr), .HOST_BUS_CLOCK(hclk), .HOST_ADDRESS_LOW(haddr),
    .HOST_BURST_N(bn), .HOST_BURST_CONTINUE(bc), .HOST_TRANSFER_SIZE(tsize),
    .HOST_ACKNOWLEDGE_N(ack_n), .CFG_BYTE(cfg_byte), .CFG_BYTE_VALID(cfg_valid));

  // ****************************************************************
  // tasks
  // ****************************************************************
  // inputs always move 1 ns after the edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // status read: state bits on D6..D3, ready on D7 when loading
  task automatic status(input logic [3:0] st, input logic load);
    rd_n = 1'h0;
    tick(4);
    chk(doe_n[7:3], 5'h00);
    chk(dout[6:3], st);
    if (load) chk(dout[7], 1'h1);
    rd_n = 1'h1;
    tick(4);
  endtask : status

  // one peripheral byte, optionally unselected or with read strobe too
  // the last byte ends loading, after which the ready pin falls quiet
  task automatic wbyte(input logic [7:0] b, input logic s, input logic r, input logic last);
    int k = 0;
    din = {24'h00_0000, b};
    sel = s;
    rd_n = r;
    wr = 1'h0;
    while (cfg_valid !== 1'h1 && k < 10) begin
      tick(1);
      k++;
    end
    chk(k < 10, s);
    if (s) chk(cfg_byte, b);
    tick(1);
    if (s) chk(rdy, 1'h0);
    if (!r) chk(doe_n[7:3], 5'h1f);
    wr = 1'h1;
    rd_n = 1'h1;
    sel = 1'h1;
    tick(8);
    chk(rdy, !last);
  endtask : wbyte

  // single host beat, host clock 160 ns, strobe set up in the low phase
  task automatic hbeat(input logic d, input logic [17:0] a, input logic [1:0] sz,
                       input logic [31:0] w, input logic [31:0] e);
    rd_n = 1'h0;
    wr = d;
    haddr = a;
    tsize = sz;
    din = w;
    tick(4);
    hclk = 1'h1;
    tick(4);
    chk(ack_n, 1'h0);
    if (d) chk(dout, e);
    if (d) chk(doe_n, 32'h0000_0000);
    hclk = 1'h0;
    rd_n = 1'h1;
    tick(4);
    hclk = 1'h1;
    tick(4);
    chk(ack_n, 1'h1);
    chk(doe_n, 32'hffff_ffff);
    hclk = 1'h0;
    tick(4);
  endtask : hbeat

  // two-beat word write burst at 8; continue stands from the first beat through the second
  task automatic hburst(input logic [31:0] w0, input logic [31:0] w1);
    rd_n = 1'h0;
    wr = 1'h0;
    haddr = 18'h0_0008;
    tsize = 2'h0;
    bn = 1'h0;
    bc = 1'h1;
    din = w0;
    tick(4);
    hclk = 1'h1;
    tick(4);
    chk(ack_n, 1'h0);
    hclk = 1'h0;
    rd_n = 1'h1;
    din = w1;
    tick(4);
    hclk = 1'h1;
    tick(4);
    chk(ack_n, 1'h0);
    hclk = 1'h0;
    bc = 1'h0;
    tick(4);
    hclk = 1'h1;
    tick(4);
    chk(ack_n, 1'h1);
    hclk = 1'h0;
    bn = 1'h1;
    tick(4);
  endtask : hburst

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    tick(6);
    nrst = 1'h1;
    tick(10);
    chk({pend_hi, pend_lo_n, init_oe_n, scan_en}, 4'h9);
    chk(init_out, 1'h0);
    sel_n = 1'h0;
    sel = 1'h1;
    tick(400);
    chk(init_oe_n, 1'h1);
    status(4'h4, 1'h0);
    hold = 1'h0;
    tick(10);
    status(4'h8, 1'h1);
    wbyte(8'h11, 1'h0, 1'h1, 1'h0);
    wbyte(8'h22, 1'h1, 1'h0, 1'h0);
    for (int i = 1; i < 16; i++) wbyte(8'(i * 13), 1'h1, 1'h1, i == 15);
    chk({pend_hi, pend_lo_n, scan_en}, 3'h2);
    hbeat(1'h0, 18'h0_0004, 2'h0, 32'h1234_5678, 32'h0000_0000);
    hbeat(1'h0, 18'h0_0005, 2'h1, 32'h00ab_0000, 32'h0000_0000);
    hbeat(1'h0, 18'h0_0006, 2'h2, 32'h0000_cdef, 32'h0000_0000);
    hbeat(1'h1, 18'h0_0004, 2'h0, 32'h0000_0000, 32'h12ab_cdef);
    hburst(32'h1357_9bdf, 32'h2468_ace0);
    hbeat(1'h1, 18'h0_0008, 2'h0, 32'h0000_0000, 32'h1357_9bdf);
    hbeat(1'h1, 18'h0_000c, 2'h0, 32'h0000_0000, 32'h2468_ace0);
    mode = 2'h1;
    nrst = 1'h0;
    tick(6);
    nrst = 1'h1;
    // power and clear take 320 cycles before init is released
    tick(320);
    for (int i = 0; i < 3; i++) begin
      for (int k = 0; k < 20 && cfg_valid !== 1'h1; k++) tick(1);
      chk(cfg_byte, 8'(i + 48));
      chk(cfg_addr, 22'(i + 1));
      chk(rdy, 1'h0);
      tick(1);
    end
    report_and_stop();
  end

  // a hang counts against the run
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule : chp_port_tb
